// ---- tape_model.sv ----
// tape transport model that turns commanded motion into marker and unload sensing
module tape_model
   import tape_panel_pkg::*;
(
   input wire logic hclk,
   input wire motion_t motion,
   input wire logic [1:0] col_flt,
   input wire logic set_en,
   input wire logic [7:0] set_pos,
   output sensors_t sns
);
   timeunit 1ns;
   timeprecision 1ns;

   // -------------------------------------------------------------
   // tape position
   // -------------------------------------------------------------
   logic [7:0] pos = 8'h00;
   logic [6:0] tick = 7'h00;

   // one step per 100 cycles at slow speed, per 50 when fast
   always @(posedge hclk) begin
      if (set_en) begin
         pos <= set_pos;
         tick <= 7'h00;
      end else if (tick >= (motion.fast ? 7'h31 : 7'h63)) begin
         tick <= 7'h00;
         if (motion.fwd) pos <= pos + 8'h01;
         else if (motion.bwd && pos != 8'h00) pos <= pos - 8'h01;
      end else begin
         tick <= tick + 7'h01;
      end
   end

   // -------------------------------------------------------------
   // sensors
   // -------------------------------------------------------------
   // marker spans eight steps so a fast pass still outlasts the debounce
   assign sns = {pos >= 8'h14 && pos <= 8'h1B, pos == 8'h00, col_flt};
endmodule

// ---- tape_panel_pkg.sv ----
// types shared by the tape panel block
package tape_panel_pkg;

   // -------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic rewind;
      logic load_point;
      logic remote_mode;
      logic local_mode;
      logic forward;
      logic backward;
      logic motors_on;
   } lamps_t;

   typedef struct packed {
      logic on;
      logic off;
      logic rewind;
      logic load_point;
      logic remote;
      logic forward;
      logic backward;
   } buttons_t;

   typedef struct packed {
      logic marker;
      logic unload;
      logic col_deep;
      logic col_out;
   } sensors_t;

   typedef struct packed {
      buttons_t btn;
      sensors_t sns;
   } inputs_t;

   typedef struct packed {
      logic fwd;
      logic bwd;
      logic fast;
   } motion_t;

   typedef struct packed {
      logic bwd_sig;
      logic fwd_sig;
      logic rew_lp;
      logic rew_il;
   } cmd_t;

   typedef logic [7:0] deb_cnt_t;

   typedef enum logic [2:0] {
      S_IDLE,
      S_REW_IL,
      S_REW_LP,
      S_LP_FWD,
      S_JOG_FWD,
      S_JOG_BWD
   } state_t;

endpackage

// ---- tape_panel_regs.svh ----
// register offsets, field positions, reset values and timing constants of the tape panel block
`ifndef TAPE_PANEL_REGS_SVH
`define TAPE_PANEL_REGS_SVH

// -------------------------------------------------------------
// register map
// -------------------------------------------------------------
`define ADDR_CMD 32'h0000_0000
`define ADDR_STATUS 32'h0000_0004
`define CMD_W 4
`define HTRANS_ACT_BIT 1

// -------------------------------------------------------------
// status field positions and reset values
// -------------------------------------------------------------
`define ST_LAMP_LSB 0
`define ST_MOT_LSB 8
`define ST_STATE_LSB 12
`define ST_PASSED_BIT 15
`define LAMPS_RST 7'h08

// -------------------------------------------------------------
// timing and speeds
// -------------------------------------------------------------
`define CLK_NS 4
`define DEB_NS 1000
`define DEB_CYC ((`DEB_NS + `CLK_NS - 1) / `CLK_NS)
`define SLOW_IPS 120
`define FAST_IPS 240
`define IN_W 11

`endif

// ---- tape_panel_rewind_loadpoint.sv ----
// rewind and load point panel control with an AHB-Lite register slave
//
// Contract
// [RQ1] rewind button starts fast reverse interlocked rewind
// [RQ2] any rewind start lights rewind lamp
// [RQ3] rewind lamp off at finish or motors-off
// [RQ4] rewind button needs local, on, not unload
// [RQ5] accepted rewind: forward off, backward on
// [RQ6] manual rewind runs to unload, then stops
// [RQ7] load point or remote press converts rewind; remote press converts only a rewind started by the rewind button
// [RQ8] button-path conversion lights local lamp at once
// [RQ9] load point lamp only with motors-on lamp
// [RQ10] load point lamp lit while marker sensed
// [RQ11] load point lamp off when marker leaves
// [RQ12] control unit signals forward motion at start
// [RQ13] forward, backward, rewind off marker clear lamp
// [RQ14] off press or column fault clear lamp
// [RQ15] marker passing under jog blinks lamp
// [RQ16] load point press: remote, forward, slow motion
// [RQ17] load point motion stops at marker
// [RQ18] load point motion stops on off or fault
// [RQ19] load point press at marker: no motion
// [RQ20] load point press converts rewind before marker
// [RQ21] off press or column fault clear motors-on
// [RQ22] lamps are flops fed by debounced inputs
`include "tape_panel_regs.svh"

module tape_panel_rewind_loadpoint
   import tape_panel_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire buttons_t panel_btn,
   input wire sensors_t tape_sns,
   output lamps_t lamps,
   output motion_t motion
);

   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   logic [`IN_W-1:0] db_r;
   logic [`IN_W-1:0] prev_r;
   deb_cnt_t cnt_r [`IN_W];
   inputs_t raw;
   inputs_t db;
   inputs_t press;
   state_t state_r;
   state_t state_nxt;
   lamps_t lamps_r;
   lamps_t lamps_nxt;
   motion_t motion_r;
   cmd_t cmd_r;
   logic passed_r;
   logic manual_r;
   logic wr_pend_r;
   logic [31:0] wr_addr_r;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic hresp_r;
   logic addr_ok, fault, ok, idle;
   logic rw_go, prog_il, prog_lp, lp_conv;
   logic lp_go, fj_go, bj_go, remote_go;
   logic start_rew, rew_done;

   // -------------------------------------------------------------
   // functions
   // -------------------------------------------------------------
   // motor drive for each motion state
   function automatic motion_t motion_of(input state_t s);
      motion_t m;
      m = '0;
      unique case (s)
         S_REW_IL, S_REW_LP: begin
            m.bwd = 1'b1;
            m.fast = 1'b1; // rewind speed
         end
         S_LP_FWD, S_JOG_FWD: m.fwd = 1'b1;
         S_JOG_BWD: m.bwd = 1'b1;
         default: m = '0;
      endcase
      return m;
   endfunction

   // register read decode
   function automatic logic [31:0] rd_mux(input logic [31:0] a);
      logic [31:0] v;
      v = '0;
      if (a == `ADDR_STATUS) begin
         v = (32'(lamps_r) << `ST_LAMP_LSB)
           | (32'(motion_r) << `ST_MOT_LSB)
           | (32'(state_r) << `ST_STATE_LSB)
           | (32'(passed_r) << `ST_PASSED_BIT);
      end
      return v;
   endfunction

   // -------------------------------------------------------------
   // input debounce
   // -------------------------------------------------------------
   assign raw = {panel_btn, tape_sns};

   // each input must stay changed for the debounce time to be taken
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         db_r <= '0;
         for (int i = 0; i < `IN_W; i++) begin
            cnt_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < `IN_W; i++) begin
            if (raw[i] == db_r[i]) begin
               cnt_r[i] <= '0;
            end else if (cnt_r[i] == deb_cnt_t'(`DEB_CYC - 1)) begin
               db_r[i] <= raw[i]; // [RQ22]
               cnt_r[i] <= '0;
            end else begin
               cnt_r[i] <= cnt_r[i] + 1'b1;
            end
         end
      end
   end

   // previous debounced levels for press edges
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_r <= '0;
      end else begin
         prev_r <= db_r;
      end
   end

   assign db = inputs_t'(db_r);
   assign press = inputs_t'(db_r & ~prev_r);

   // -------------------------------------------------------------
   // event decode
   // -------------------------------------------------------------
   assign fault = press.btn.off | db.sns.col_deep | db.sns.col_out;
   assign ok = lamps_r.local_mode & lamps_r.motors_on;
   assign idle = (state_r == S_IDLE);
   assign rw_go = idle & press.btn.rewind & ok & ~db.sns.unload & ~fault; // [RQ4]
   assign prog_il = idle & cmd_r.rew_il & lamps_r.motors_on & ~db.sns.unload & ~fault;
   assign prog_lp = idle & cmd_r.rew_lp & lamps_r.motors_on & ~fault;
   // conversion only before the marker went by [RQ7] [RQ20]
   assign lp_conv = (state_r == S_REW_IL) & ~passed_r & ~fault & ~db.sns.unload
                  & (press.btn.load_point | (manual_r & press.btn.remote));
   assign lp_go = idle & press.btn.load_point & ok & ~fault & ~rw_go & ~prog_il & ~prog_lp;
   assign fj_go = idle & press.btn.forward & ok & ~fault & ~rw_go & ~prog_il & ~prog_lp & ~lp_go;
   assign bj_go = idle & press.btn.backward & ok & ~fault & ~rw_go & ~prog_il & ~prog_lp
                & ~lp_go & ~fj_go;
   assign remote_go = idle & press.btn.remote & ok & ~fault & ~rw_go & ~lp_go;

   // -------------------------------------------------------------
   // motion state
   // -------------------------------------------------------------
   // next motion state; faults abort every motion
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         S_IDLE: begin
            if (rw_go | prog_il) begin
               state_nxt = S_REW_IL; // [RQ1]
            end else if (prog_lp) begin
               state_nxt = S_REW_LP;
            end else if (lp_go & ~db.sns.marker) begin
               state_nxt = S_LP_FWD; // [RQ16] [RQ19]
            end else if (fj_go) begin
               state_nxt = S_JOG_FWD;
            end else if (bj_go & ~db.sns.unload) begin
               state_nxt = S_JOG_BWD;
            end
         end
         S_REW_IL: begin
            if (fault | db.sns.unload) begin
               state_nxt = S_IDLE; // [RQ6]
            end else if (lp_conv) begin
               state_nxt = S_REW_LP; // [RQ7] [RQ20]
            end
         end
         S_REW_LP: begin
            if (fault | db.sns.marker) begin
               state_nxt = S_IDLE;
            end
         end
         S_LP_FWD: begin
            if (fault | db.sns.marker) begin
               state_nxt = S_IDLE; // [RQ17] [RQ18]
            end
         end
         S_JOG_FWD: begin
            if (fault | ~db.btn.forward) begin
               state_nxt = S_IDLE;
            end
         end
         S_JOG_BWD: begin
            if (fault | ~db.btn.backward | db.sns.unload) begin
               state_nxt = S_IDLE;
            end
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   assign start_rew = idle & ((state_nxt == S_REW_IL) | (state_nxt == S_REW_LP));
   assign rew_done = ((state_r == S_REW_IL) | (state_r == S_REW_LP)) & (state_nxt == S_IDLE);

   // state and motor drive registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= S_IDLE;
         motion_r <= '0;
      end else begin
         state_r <= state_nxt;
         motion_r <= motion_of(state_nxt); // [RQ1] [RQ16]
      end
   end

   // marker passed during interlocked rewind, and who started it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         passed_r <= 1'b0;
         manual_r <= 1'b0;
      end else if (start_rew) begin
         passed_r <= 1'b0;
         manual_r <= rw_go;
      end else if ((state_r == S_REW_IL) & db.sns.marker) begin
         passed_r <= 1'b1; // [RQ20]
      end
   end

   // -------------------------------------------------------------
   // panel lamps
   // -------------------------------------------------------------
   // lamp next state from presses, motion and sensors
   always_comb begin
      lamps_nxt = lamps_r;
      if (press.btn.on) begin
         lamps_nxt.motors_on = 1'b1;
      end
      if (fault) begin
         lamps_nxt.motors_on = 1'b0; // [RQ21]
      end
      if (press.btn.off) begin
         lamps_nxt.remote_mode = 1'b0;
         lamps_nxt.local_mode = 1'b1;
      end
      if (start_rew) begin
         lamps_nxt.rewind = 1'b1; // [RQ2]
      end
      if (rew_done | fault) begin
         lamps_nxt.rewind = 1'b0; // [RQ3]
      end
      if (rw_go | prog_il | prog_lp | bj_go | cmd_r.bwd_sig) begin
         lamps_nxt.forward = 1'b0; // [RQ5]
         lamps_nxt.backward = 1'b1;
      end
      if (lp_go | fj_go | cmd_r.fwd_sig) begin
         lamps_nxt.forward = 1'b1; // [RQ12]
         lamps_nxt.backward = 1'b0;
      end
      if (lp_go | remote_go) begin
         lamps_nxt.local_mode = 1'b0; // [RQ16]
         lamps_nxt.remote_mode = 1'b1;
      end
      if (lp_conv & manual_r) begin
         lamps_nxt.local_mode = 1'b1; // [RQ8]
      end
      // marker level drives the lamp, so motion off it clears it [RQ9] [RQ10] [RQ11] [RQ13] [RQ14] [RQ15]
      lamps_nxt.load_point = lamps_nxt.motors_on & db.sns.marker;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lamps_r <= lamps_t'(`LAMPS_RST);
      end else begin
         lamps_r <= lamps_nxt; // [RQ22]
      end
   end

   // -------------------------------------------------------------
   // AHB-Lite slave
   // -------------------------------------------------------------
   assign addr_ok = hsel & hready & htrans[`HTRANS_ACT_BIT];

   // address phase capture for writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
      end else begin
         wr_pend_r <= addr_ok & hwrite;
         if (addr_ok) begin
            wr_addr_r <= haddr;
         end
      end
   end

   // command bits are one-cycle pulses taken at the end of the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_r <= '0;
      end else if (wr_pend_r & (wr_addr_r == `ADDR_CMD)) begin
         cmd_r <= cmd_t'(hwdata[`CMD_W-1:0]);
      end else begin
         cmd_r <= '0;
      end
   end

   // read data prepared in the address phase, zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= '0;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end else begin
         hrdata_r <= (addr_ok & ~hwrite) ? rd_mux(haddr) : '0;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;
   assign lamps = lamps_r;
   assign motion = motion_r;

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence seq_rw_accept;
      idle && press.btn.rewind && ok && !db.sns.unload && !fault;
   endsequence
   sequence seq_lp_press;
      idle && press.btn.load_point && ok && !fault && !press.btn.rewind && cmd_r == '0;
   endsequence
   sequence seq_conv_hit;
      state_r == S_REW_IL && !passed_r && !fault && !db.sns.unload && press.btn.load_point;
   endsequence
   sequence seq_conv_rem;
      state_r == S_REW_IL && !passed_r && !fault && !db.sns.unload && manual_r && press.btn.remote;
   endsequence

   a_lp_needs_on: assert property (lamps_r.load_point |-> lamps_r.motors_on) // [RQ9]
      else $error("load point lamp lit without motors-on lamp");
   a_lp_marker_on: assert property ($rose(db.sns.marker) && lamps_r.motors_on && !fault // [RQ10]
      |=> lamps_r.load_point)
      else $error("load point lamp missed marker");
   a_lp_marker_off: assert property ($fell(db.sns.marker) |=> !lamps_r.load_point) // [RQ11]
      else $error("load point lamp stayed after marker left");
   a_rw_start: assert property (seq_rw_accept |=> lamps_r.rewind && lamps_r.backward // [RQ1]
      && !lamps_r.forward && motion_r.bwd && motion_r.fast)
      else $error("rewind press did not start rewind");
   a_rw_ignored: assert property (idle && press.btn.rewind && !ok && cmd_r == '0 // [RQ4]
      |=> state_r == S_IDLE && !lamps_r.rewind)
      else $error("rewind press acted without local and on");
   a_fault_stop: assert property (fault |=> !lamps_r.motors_on && !lamps_r.rewind // [RQ21]
      && !lamps_r.load_point && motion_r == '0)
      else $error("fault left motors or lamps on");
   a_unload_stop: assert property (state_r == S_REW_IL && db.sns.unload && !fault // [RQ6]
      |=> state_r == S_IDLE ##0 !lamps_r.rewind && motion_r == '0)
      else $error("rewind did not stop at unload point");
   a_conv_taken: assert property (seq_conv_hit |=> state_r == S_REW_LP) // [RQ20]
      else $error("load point press did not convert rewind");
   a_conv_remote: assert property (seq_conv_rem |=> state_r == S_REW_LP) // [RQ7]
      else $error("remote press did not convert rewind");
   a_conv_local: assert property ((seq_conv_hit and manual_r) or seq_conv_rem |=> lamps_r.local_mode) // [RQ8]
      else $error("conversion did not light local lamp");
   a_lp_go: assert property (seq_lp_press and !db.sns.marker |=> motion_r.fwd // [RQ16]
      && !motion_r.fast && lamps_r.remote_mode && !lamps_r.local_mode)
      else $error("load point press did not start slow forward");
   a_lp_no_move: assert property (seq_lp_press and db.sns.marker |=> motion_r == '0) // [RQ19]
      else $error("load point press at marker moved tape");
   a_lp_stop: assert property (state_r == S_LP_FWD && db.sns.marker // [RQ17]
      |=> !motion_r.fwd ##1 state_r == S_IDLE)
      else $error("load point motion ran past marker");
   a_rlp_done: assert property (state_r == S_REW_LP && db.sns.marker && !fault // [RQ3]
      |=> !lamps_r.rewind && lamps_r.load_point)
      else $error("rewind to marker did not finish");

endmodule

// ---- tape_panel_rewind_loadpoint_test.sv ----
// self-checking bench for the tape panel rewind and load point block
`include "tape_panel_regs.svh"

module tape_panel_rewind_loadpoint_test
   import tape_panel_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // -------------------------------------------------------------
   // signals
   // -------------------------------------------------------------
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   buttons_t panel_btn = 7'h00;
   sensors_t tape_sns;
   lamps_t lamps;
   motion_t motion;
   logic [1:0] col_flt = 2'h0;
   logic set_en = 1'b0;
   logic [7:0] set_pos = 8'h00;
   logic [31:0] rd;
   int n_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   localparam buttons_t on_b = 7'h40;
   localparam buttons_t off_b = 7'h20;
   localparam buttons_t rew_b = 7'h10;
   localparam buttons_t lp_b = 7'h08;
   localparam buttons_t rem_b = 7'h04;
   localparam buttons_t fwd_b = 7'h02;

   tape_panel_rewind_loadpoint u_tape_panel_rewind_loadpoint (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(3'h2),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .panel_btn(panel_btn),
      .tape_sns(tape_sns),
      .lamps(lamps),
      .motion(motion)
   );

   tape_model u_tape_model (
      .hclk(hclk),
      .motion(motion),
      .col_flt(col_flt),
      .set_en(set_en),
      .set_pos(set_pos),
      .sns(tape_sns)
   );

   // -------------------------------------------------------------
   // clock, timeout and helpers
   // -------------------------------------------------------------
   // 4 ns period
   initial begin
      forever #2 hclk = ~hclk;
   end

   // cuts a hang short
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // single word transfer; read data taken at the data phase edge
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // hold a button past the debounce, then release it past it again
   task automatic press(input buttons_t b);
      @(posedge hclk);
      panel_btn <= b;
      repeat (260) @(posedge hclk);
      panel_btn <= 7'h00;
      repeat (260) @(posedge hclk);
   endtask

   // move the tape model to a position and let the sensors settle
   task automatic put(input logic [7:0] p);
      @(posedge hclk);
      set_en <= 1'b1;
      set_pos <= p;
      @(posedge hclk);
      set_en <= 1'b0;
      repeat (260) @(posedge hclk);
   endtask

   task automatic wait_stop();
      for (int i = 0; i < 8000 && motion !== 3'h0; i++) @(posedge hclk);
      repeat (4) @(posedge hclk);
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_power();
      chk(32'(lamps), 32'h08);
      press(rew_b);
      chk(32'(motion), 32'h0);
      press(on_b);
      chk(32'(lamps), 32'h09);
      press(rew_b);
      chk(32'(motion), 32'h0);
      chk(32'(lamps), 32'h09);
   endtask

   task automatic t_load_run();
      press(lp_b);
      chk(32'(motion), 32'h4);
      chk(32'(lamps & 7'h1C), 32'h14);
      wait_stop();
      chk(32'(lamps.load_point), 32'h1);
      chk(32'(tape_sns.marker), 32'h1);
   endtask

   task automatic t_off_on();
      press(off_b);
      chk(32'(lamps.load_point), 32'h0);
      chk(32'(lamps.motors_on), 32'h0);
      press(on_b);
      chk(32'(lamps.load_point), 32'h1);
      press(lp_b);
      chk(32'(motion), 32'h0);
   endtask

   task automatic t_rewind();
      press(off_b);
      press(on_b);
      chk(32'(lamps.load_point), 32'h1);
      press(rew_b);
      chk(32'(lamps & 7'h46), 32'h42);
      chk(32'(motion), 32'h3);
      wait_stop();
      chk(32'(lamps.rewind), 32'h0);
      chk(32'(lamps.load_point), 32'h0);
      chk(32'(tape_sns.unload), 32'h1);
   endtask

   task automatic t_convert();
      put(8'h3C);
      press(rew_b);
      press(rem_b);
      chk(32'(lamps.local_mode), 32'h1);
      wait_stop();
      chk(32'(lamps.load_point), 32'h1);
      chk(32'(tape_sns.marker), 32'h1);
      chk(32'(lamps.rewind), 32'h0);
   endtask

   task automatic t_fault();
      put(8'h00);
      press(lp_b);
      chk(32'(motion), 32'h4);
      @(posedge hclk);
      col_flt <= 2'h1;
      repeat (260) @(posedge hclk);
      chk(32'(motion), 32'h0);
      chk(32'(lamps.motors_on), 32'h0);
      chk(32'(tape_sns.marker), 32'h0);
      col_flt <= 2'h0;
      repeat (260) @(posedge hclk);
      press(off_b);
   endtask

   task automatic t_prog();
      press(on_b);
      put(8'h32);
      bus(1'b1, `ADDR_CMD, 32'h1);
      repeat (4) @(posedge hclk);
      bus(1'b0, `ADDR_STATUS, 32'h0);
      chk(32'(rd[6]), 32'h1);
      chk(32'(rd[10:8]), 32'h3);
      press(lp_b);
      wait_stop();
      chk(32'(lamps.load_point), 32'h1);
      chk(32'(tape_sns.marker), 32'h1);
      bus(1'b0, 32'h0000_0008, 32'h0);
      chk(rd, 32'h0);
   endtask

   // control unit motion signals, forward jog off the marker, program rewind to marker
   task automatic t_cmd();
      bus(1'b1, `ADDR_CMD, 32'h4);
      repeat (2) @(posedge hclk);
      chk(32'(lamps & 7'h06), 32'h04);
      @(posedge hclk);
      panel_btn <= fwd_b;
      repeat (260) @(posedge hclk);
      chk(32'(motion), 32'h4);
      repeat (1200) @(posedge hclk);
      chk(32'(lamps.load_point), 32'h0);
      panel_btn <= 7'h00;
      repeat (260) @(posedge hclk);
      chk(32'(motion), 32'h0);
      bus(1'b1, `ADDR_CMD, 32'h8);
      repeat (2) @(posedge hclk);
      chk(32'(lamps & 7'h06), 32'h02);
      bus(1'b1, `ADDR_CMD, 32'h2);
      repeat (2) @(posedge hclk);
      chk(32'(lamps.rewind), 32'h1);
      wait_stop();
      chk(32'(lamps & 7'h60), 32'h20);
   endtask

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_power();
      t_load_run();
      t_off_on();
      t_rewind();
      t_convert();
      t_fault();
      t_prog();
      t_cmd();
      results();
   end
endmodule
